// file: verilog/eqc_consts.vh
// eqc_consts.vh: offsets, fields, reset values and timing counts of the equalizer control block
//
// Summary of operation
// - four channels, eight boost levels each
// - pin code drives all four channels alike
// - open boost pins read as 3'b100
// - source select high: pins; low: registers
// - open source select reads high
// - per-channel enable; low puts that channel standby
// - open channel enables read high
// - per-channel signal detect output, high when present
// - management-bus register access only while access select high
// - data line two-way, clock input, both pulled high
// - detect hysteresis: on at 70, off at 40 mV
// - bus clock low 25-35 ms aborts transaction
`ifndef EQC_CONSTS_VH
`define EQC_CONSTS_VH

// apb byte offsets
`define EQC_REG_STATUS 8'h00
`define EQC_REG_BOOST 8'h04
`define EQC_REG_THRESH 8'h08
`define EQC_REG_INT_STAT 8'h0C
`define EQC_REG_INT_MASK 8'h10

// boost register: 3-bit field per channel, stride 4 bits
`define EQC_BOOST_W 3
`define EQC_BOOST_STRIDE 4
`define EQC_BOOST_RST 16'h0000

// status register fields
`define EQC_ST_PIN_CODE_LSB 0
`define EQC_ST_SRC_SEL 3
`define EQC_ST_EN_LSB 4
`define EQC_ST_SD_LSB 8
`define EQC_ST_ACC_SEL 12

// threshold register fields and defaults (mV peak-to-peak)
`define EQC_TH_ON_LSB 0
`define EQC_TH_OFF_LSB 8
`define EQC_SD_ON_MV 8'h46
`define EQC_SD_OFF_MV 8'h28

// interrupt bits: [3:0] detect rise, [7:4] detect fall, [8] bus timeout
`define EQC_INT_W 9
`define EQC_INT_RISE_LSB 0
`define EQC_INT_FALL_LSB 4
`define EQC_INT_TMO 8
`define EQC_INT_MASK_RST 9'h000

// pad pull levels, used as synchroniser reset values
`define EQC_BOOST_PIN_RST 3'h4
`define EQC_SRC_SEL_RST 1'h1
`define EQC_EN_RST 4'hF
`define EQC_ACC_SEL_RST 1'h0
`define EQC_SMB_LINE_RST 2'h3

// timing
`define EQC_CLK_KHZ 200000
`define EQC_TMO_MIN_MS 25
`define EQC_TMO_MAX_MS 35
`define EQC_TMO_CYC (`EQC_TMO_MIN_MS * `EQC_CLK_KHZ)

// management bus slave address, value arbitrary
`define EQC_SMB_ADDR 7'h2C

`endif

// file: verilog/eqc_sync.v
// eqc_sync.v: two-flop synchroniser for pad inputs
`timescale 1ns/1ps
module eqc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_r;

  // reset value is the pad pull level, so an open pin reads its default at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// file: verilog/eqc_top.v
// eqc_top.v: control plane of the four-channel equalizer
`timescale 1ns/1ps
`include "eqc_consts.vh"
module eqc_top #(
  parameter [31:0] TMO_CYCLES = `EQC_TMO_CYC,
  parameter [6:0] SMB_ADDR = `EQC_SMB_ADDR
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire boost_sel_msb,
  input wire boost_sel_mid,
  input wire boost_sel_lsb,
  input wire boost_source_select,
  input wire chan0_enable,
  input wire chan1_enable,
  input wire chan2_enable,
  input wire chan3_enable,
  input wire reg_access_select,
  input wire mgmt_bus_clock_pin,
  input wire mgmt_bus_data_in,
  output reg mgmt_bus_data_out,
  output reg mgmt_bus_data_oe_n,
  input wire [7:0] chan0_amp_mv,
  input wire [7:0] chan1_amp_mv,
  input wire [7:0] chan2_amp_mv,
  input wire [7:0] chan3_amp_mv,
  output reg [2:0] chan0_eq_level,
  output reg [2:0] chan1_eq_level,
  output reg [2:0] chan2_eq_level,
  output reg [2:0] chan3_eq_level,
  output reg chan0_standby,
  output reg chan1_standby,
  output reg chan2_standby,
  output reg chan3_standby,
  output wire chan0_sig_detect,
  output wire chan1_sig_detect,
  output wire chan2_sig_detect,
  output wire chan3_sig_detect,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pad synchronisers

  localparam [10:0] PIN_RST = {`EQC_BOOST_PIN_RST, `EQC_SRC_SEL_RST, `EQC_EN_RST,
                               `EQC_ACC_SEL_RST, `EQC_SMB_LINE_RST};

  wire [10:0] pin_q;
  wire [2:0] pin_code;
  wire src_sel_pins;
  wire [3:0] chan_en;
  wire acc_sel;
  wire scl_s;
  wire sda_s;

  // open pads resolve to their pull levels at reset
  eqc_sync #(
    .WIDTH(11),
    .RST_VAL(PIN_RST)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({boost_sel_msb, boost_sel_mid, boost_sel_lsb, boost_source_select,
        chan3_enable, chan2_enable, chan1_enable, chan0_enable,
        reg_access_select, mgmt_bus_clock_pin, mgmt_bus_data_in}),
    .q(pin_q)
  );

  assign pin_code = pin_q[10:8];
  assign src_sel_pins = pin_q[7];
  assign chan_en = pin_q[6:3];
  assign acc_sel = pin_q[2];
  assign scl_s = pin_q[1];
  assign sda_s = pin_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg [15:0] boost_r;
  reg [15:0] boost_nxt;
  reg [7:0] th_on_r;
  reg [7:0] th_off_r;
  reg [`EQC_INT_W-1:0] int_stat_r;
  reg [`EQC_INT_W-1:0] int_stat_nxt;
  reg [`EQC_INT_W-1:0] int_mask_r;
  reg [3:0] sd_r;
  reg [3:0] sd_nxt;
  reg tmo_evt;
  reg smb_wr;
  reg [1:0] smb_wr_chan;
  reg [2:0] smb_wr_val;

  wire apb_wr = psel & penable & pwrite;
  wire apb_setup = psel & ~penable;

  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // apb read path: data and error registered in the setup cycle

  reg [31:0] rd_nxt;
  reg err_nxt;

  always @* begin
    rd_nxt = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
      `EQC_REG_STATUS: begin
        rd_nxt[`EQC_ST_PIN_CODE_LSB +: 3] = pin_code;
        rd_nxt[`EQC_ST_SRC_SEL] = src_sel_pins;
        rd_nxt[`EQC_ST_EN_LSB +: 4] = chan_en;
        rd_nxt[`EQC_ST_SD_LSB +: 4] = sd_r;
        rd_nxt[`EQC_ST_ACC_SEL] = acc_sel;
      end
      `EQC_REG_BOOST: rd_nxt[15:0] = boost_r;
      `EQC_REG_THRESH: begin
        rd_nxt[`EQC_TH_ON_LSB +: 8] = th_on_r;
        rd_nxt[`EQC_TH_OFF_LSB +: 8] = th_off_r;
      end
      `EQC_REG_INT_STAT: rd_nxt[`EQC_INT_W-1:0] = int_stat_r;
      `EQC_REG_INT_MASK: rd_nxt[`EQC_INT_W-1:0] = int_mask_r;
      default: err_nxt = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_nxt;
      pslverr <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel register boost; apb wins over the serial port in a tie

  integer i;
  integer j;

  always @* begin
    boost_nxt = boost_r;
    if (smb_wr) begin
      boost_nxt[smb_wr_chan * `EQC_BOOST_STRIDE +: `EQC_BOOST_W] = smb_wr_val;
    end
    if (apb_wr && paddr == `EQC_REG_BOOST) begin
      for (i = 0; i < 4; i = i + 1) begin
        boost_nxt[i * `EQC_BOOST_STRIDE +: `EQC_BOOST_W] =
          pwdata[i * `EQC_BOOST_STRIDE +: `EQC_BOOST_W];
      end
    end
  end

  // hardware-set events win over a same-cycle write-one-to-clear
  always @* begin
    int_stat_nxt = int_stat_r;
    if (apb_wr && paddr == `EQC_REG_INT_STAT) begin
      int_stat_nxt = int_stat_r & ~pwdata[`EQC_INT_W-1:0];
    end
    int_stat_nxt[`EQC_INT_RISE_LSB +: 4] = int_stat_nxt[`EQC_INT_RISE_LSB +: 4] | (sd_nxt & ~sd_r);
    int_stat_nxt[`EQC_INT_FALL_LSB +: 4] = int_stat_nxt[`EQC_INT_FALL_LSB +: 4] | (sd_r & ~sd_nxt);
    int_stat_nxt[`EQC_INT_TMO] = int_stat_nxt[`EQC_INT_TMO] | tmo_evt;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_r <= `EQC_BOOST_RST;
      th_on_r <= `EQC_SD_ON_MV;
      th_off_r <= `EQC_SD_OFF_MV;
      int_stat_r <= {`EQC_INT_W{1'b0}};
      int_mask_r <= `EQC_INT_MASK_RST;
      irq <= 1'b0;
    end else begin
      boost_r <= boost_nxt;
      int_stat_r <= int_stat_nxt;
      irq <= |(int_stat_nxt & int_mask_r);
      if (apb_wr && paddr == `EQC_REG_THRESH) begin
        th_on_r <= pwdata[`EQC_TH_ON_LSB +: 8];
        th_off_r <= pwdata[`EQC_TH_OFF_LSB +: 8];
      end
      if (apb_wr && paddr == `EQC_REG_INT_MASK) begin
        int_mask_r <= pwdata[`EQC_INT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boost selection, standby and signal detect

  wire [31:0] amp_all = {chan3_amp_mv, chan2_amp_mv, chan1_amp_mv, chan0_amp_mv};

  // hysteresis: set at or above the on level, clear at or below the off level
  always @* begin
    for (j = 0; j < 4; j = j + 1) begin
      if (!chan_en[j]) begin
        sd_nxt[j] = 1'b0;
      end else if (amp_all[j * 8 +: 8] >= th_on_r) begin
        sd_nxt[j] = 1'b1;
      end else if (amp_all[j * 8 +: 8] <= th_off_r) begin
        sd_nxt[j] = 1'b0;
      end else begin
        sd_nxt[j] = sd_r[j];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_r <= 4'h0;
      chan0_eq_level <= `EQC_BOOST_PIN_RST;
      chan1_eq_level <= `EQC_BOOST_PIN_RST;
      chan2_eq_level <= `EQC_BOOST_PIN_RST;
      chan3_eq_level <= `EQC_BOOST_PIN_RST;
      chan0_standby <= 1'b0;
      chan1_standby <= 1'b0;
      chan2_standby <= 1'b0;
      chan3_standby <= 1'b0;
    end else begin
      sd_r <= sd_nxt;
      if (src_sel_pins) begin
        chan0_eq_level <= pin_code;
        chan1_eq_level <= pin_code;
        chan2_eq_level <= pin_code;
        chan3_eq_level <= pin_code;
      end else begin
        chan0_eq_level <= boost_r[0 * `EQC_BOOST_STRIDE +: `EQC_BOOST_W];
        chan1_eq_level <= boost_r[1 * `EQC_BOOST_STRIDE +: `EQC_BOOST_W];
        chan2_eq_level <= boost_r[2 * `EQC_BOOST_STRIDE +: `EQC_BOOST_W];
        chan3_eq_level <= boost_r[3 * `EQC_BOOST_STRIDE +: `EQC_BOOST_W];
      end
      chan0_standby <= ~chan_en[0];
      chan1_standby <= ~chan_en[1];
      chan2_standby <= ~chan_en[2];
      chan3_standby <= ~chan_en[3];
    end
  end

  assign chan0_sig_detect = sd_r[0];
  assign chan1_sig_detect = sd_r[1];
  assign chan2_sig_detect = sd_r[2];
  assign chan3_sig_detect = sd_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // management-bus write slave: address, pointer (channel), then data bytes

  localparam [2:0] SM_IDLE = 3'h0;
  localparam [2:0] SM_ADDR = 3'h1;
  localparam [2:0] SM_PTR = 3'h2;
  localparam [2:0] SM_DATA = 3'h3;
  localparam [2:0] SM_SKIP = 3'h4;

  reg [2:0] sm_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [1:0] ptr_r;
  reg scl_d_r;
  reg sda_d_r;
  reg [31:0] low_cnt_r;

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire tmo_hit = (low_cnt_r == TMO_CYCLES - 32'h00000001) & ~scl_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      low_cnt_r <= 32'h00000000;
      tmo_evt <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      tmo_evt <= tmo_hit;
      // counter parks one past the limit so the timeout fires once per low spell
      if (scl_s) begin
        low_cnt_r <= 32'h00000000;
      end else if (low_cnt_r != TMO_CYCLES) begin
        low_cnt_r <= low_cnt_r + 32'h00000001;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sm_r <= SM_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 2'h0;
      mgmt_bus_data_out <= 1'b0;
      mgmt_bus_data_oe_n <= 1'b1;
      smb_wr <= 1'b0;
      smb_wr_chan <= 2'h0;
      smb_wr_val <= 3'h0;
    end else begin
      smb_wr <= 1'b0;
      mgmt_bus_data_out <= 1'b0;
      if (tmo_hit || !acc_sel) begin
        // abandon: release the data line and wait for a fresh start
        sm_r <= SM_IDLE;
        bit_cnt_r <= 4'h0;
        mgmt_bus_data_oe_n <= 1'b1;
      end else if (bus_stop) begin
        sm_r <= SM_IDLE;
        bit_cnt_r <= 4'h0;
        mgmt_bus_data_oe_n <= 1'b1;
      end else if (bus_start) begin
        sm_r <= SM_ADDR;
        bit_cnt_r <= 4'h0;
        mgmt_bus_data_oe_n <= 1'b1;
      end else if (scl_rise && bit_cnt_r < 4'h8 && sm_r != SM_IDLE) begin
        shift_r <= {shift_r[6:0], sda_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (scl_fall && bit_cnt_r == 4'h8) begin
        bit_cnt_r <= 4'h9;
        case (sm_r)
          SM_ADDR: begin
            // only write transfers to our address are acknowledged
            if (shift_r[7:1] == SMB_ADDR && !shift_r[0]) begin
              sm_r <= SM_PTR;
              mgmt_bus_data_oe_n <= 1'b0;
            end else begin
              sm_r <= SM_SKIP;
            end
          end
          SM_PTR: begin
            ptr_r <= shift_r[1:0];
            sm_r <= SM_DATA;
            mgmt_bus_data_oe_n <= 1'b0;
          end
          SM_DATA: begin
            smb_wr <= 1'b1;
            smb_wr_chan <= ptr_r;
            smb_wr_val <= shift_r[2:0];
            ptr_r <= ptr_r + 2'h1;
            mgmt_bus_data_oe_n <= 1'b0;
          end
          default: sm_r <= SM_SKIP;
        endcase
      end else if (scl_fall && bit_cnt_r == 4'h9) begin
        bit_cnt_r <= 4'h0;
        mgmt_bus_data_oe_n <= 1'b1;
      end
    end
  end

endmodule

// file: verification/eqc_top_monitor.sv
// eqc_top_monitor.sv: port assertions for the equalizer control block
`timescale 1ns/1ps
module eqc_top_monitor #(
  parameter [31:0] TMO_CYCLES = 32'h004C4B40
) (
  input wire pclk,
  input wire presetn,
  input wire boost_sel_msb,
  input wire boost_sel_mid,
  input wire boost_sel_lsb,
  input wire boost_source_select,
  input wire chan0_enable,
  input wire reg_access_select,
  input wire mgmt_bus_data_out,
  input wire mgmt_bus_data_oe_n,
  input wire [7:0] chan0_amp_mv,
  input wire [2:0] chan0_eq_level,
  input wire [2:0] chan1_eq_level,
  input wire [2:0] chan2_eq_level,
  input wire [2:0] chan3_eq_level,
  input wire chan0_standby,
  input wire chan0_sig_detect
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [2:0] pin_code = {boost_sel_msb, boost_sel_mid, boost_sel_lsb};
  // two sync flops plus the output register: four steady cycles are enough
  sequence s_pins_held;
    (boost_source_select && $stable(pin_code))[*4];
  endsequence
  sequence s_loud_running;
    (!chan0_standby && chan0_amp_mv >= 8'h46)[*3];
  endsequence
  a_pin_code_all: assert property (s_pins_held |-> chan0_eq_level == pin_code &&
    chan1_eq_level == pin_code && chan2_eq_level == pin_code && chan3_eq_level == pin_code)
    else $error("pin code not applied to every channel");
  a_standby_when_low: assert property ((!chan0_enable)[*4] |-> chan0_standby)
    else $error("channel not in standby while enable low");
  a_run_when_high: assert property (chan0_enable[*4] |-> !chan0_standby)
    else $error("channel in standby while enable high");
  a_detect_on_level: assert property (s_loud_running |-> chan0_sig_detect)
    else $error("signal detect missing above on level");
  a_detect_off_level: assert property (chan0_amp_mv <= 8'h28 |=> !chan0_sig_detect)
    else $error("signal detect held below off level");
  a_standby_no_detect: assert property (chan0_standby[*2] |-> !chan0_sig_detect)
    else $error("signal detect high in standby");
  a_access_line_free: assert property ((!reg_access_select)[*4] |-> mgmt_bus_data_oe_n)
    else $error("data line driven while access select low");
  a_data_pull_only: assert property (!mgmt_bus_data_oe_n |-> !mgmt_bus_data_out)
    else $error("data line driven high");
endmodule
bind eqc_top eqc_top_monitor #(.TMO_CYCLES(TMO_CYCLES)) eqc_top_monitor_inst (.*);

// file: verification/eqc_smb_host.sv
// eqc_smb_host.sv: management bus host model, open-drain data, clock driven push-pull
`timescale 1ns/1ps
module eqc_smb_host #(
  parameter int HALF = 8
) (
  input wire pclk,
  input wire sda_line,
  output logic scl,
  output logic sda_drv
);
  // clock rests high between frames, as the pull-up leaves it
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic start_frame();
    sda_drv <= 1'b0;
    wt(HALF);
    scl <= 1'b0;
    wt(HALF);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv <= b[i];
      wt(HALF);
      scl <= 1'b1;
      wt(HALF);
      scl <= 1'b0;
    end
    // released line: the pull-up, not the last bit, decides its level
    sda_drv <= 1'b1;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    ack = !sda_line;
    scl <= 1'b0;
    wt(HALF);
  endtask
  task automatic stop_frame();
    sda_drv <= 1'b0;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF);
    sda_drv <= 1'b1;
    wt(HALF);
  endtask
endmodule

// file: verification/testbench.sv
// testbench.sv: self-checking bench for the equalizer control block
`timescale 1ns/1ps
`include "eqc_consts.vh"
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, src = 1, acc = 0, ack;
  logic [7:0] paddr = 0, amp0 = 0, amp1 = 0, amp2 = 0, amp3 = 0;
  logic [31:0] pwdata = 0;
  logic [2:0] pins = 3'h4;
  logic [3:0] en = 4'hF;
  wire [31:0] prdata;
  wire pready, pslverr, irq, sda_out, sda_oe_n, scl, sda_drv;
  wire [2:0] eq0, eq1, eq2, eq3;
  wire [3:0] sb, sd;
  wire [11:0] eqv = {eq3, eq2, eq1, eq0};
  wire sda_line = sda_drv & (sda_oe_n | sda_out);
  int bad_count = 0, comparisons = 0;
  eqc_top #(.TMO_CYCLES(32'h000000C8)) eqc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .boost_sel_msb(pins[2]), .boost_sel_mid(pins[1]),
    .boost_sel_lsb(pins[0]), .boost_source_select(src), .chan0_enable(en[0]),
    .chan1_enable(en[1]), .chan2_enable(en[2]), .chan3_enable(en[3]), .reg_access_select(acc),
    .mgmt_bus_clock_pin(scl), .mgmt_bus_data_in(sda_line), .mgmt_bus_data_out(sda_out),
    .mgmt_bus_data_oe_n(sda_oe_n), .chan0_amp_mv(amp0), .chan1_amp_mv(amp1),
    .chan2_amp_mv(amp2), .chan3_amp_mv(amp3), .chan0_eq_level(eq0), .chan1_eq_level(eq1),
    .chan2_eq_level(eq2), .chan3_eq_level(eq3), .chan0_standby(sb[0]), .chan1_standby(sb[1]),
    .chan2_standby(sb[2]), .chan3_standby(sb[3]), .chan0_sig_detect(sd[0]),
    .chan1_sig_detect(sd[1]), .chan2_sig_detect(sd[2]), .chan3_sig_detect(sd[3]), .irq(irq));
  eqc_smb_host eqc_smb_host_inst (.pclk(pclk), .sda_line(sda_line), .scl(scl),
    .sda_drv(sda_drv));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    comparisons++;
    if (got !== x) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, x, got);
    end
  endtask
  // one idle edge after each transfer keeps every signal to one assignment per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    chk("pready_wait", 32'h1, {31'h0, n < 50});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask
  task automatic smb(input logic [7:0] b, input logic xa);
    eqc_smb_host_inst.send_byte(b, ack);
    chk("ack", {31'h0, xa}, {31'h0, ack});
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("eq", 32'h924, {20'h0, eqv});
    chk("standby", 32'h0, {28'h0, sb});
    rd("status", `EQC_REG_STATUS, 32'hFC, 1'b0);
    rd("thresh", `EQC_REG_THRESH, 32'h2846, 1'b0);
    rd("boost", `EQC_REG_BOOST, 32'h0, 1'b0);
    rd("mask", `EQC_REG_INT_MASK, 32'h0, 1'b0);
    rd("hole", 8'h14, 32'h0, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_levels();
    for (int c = 0; c < 8; c++) begin
      pins <= c[2:0];
      wt(5);
      chk("eq", {20'h0, {4{c[2:0]}}}, {20'h0, eqv});
    end
    pins <= 3'h4;
    wr(`EQC_REG_BOOST, 32'h7531);
    src <= 1'b0;
    wt(5);
    chk("eq", 32'hF59, {20'h0, eqv});
    src <= 1'b1;
    wt(5);
    chk("eq", 32'h924, {20'h0, eqv});
    for (int i = 0; i < 4; i++) begin
      en <= ~(4'h1 << i);
      wt(5);
      chk("standby", 32'h1 << i, {28'h0, sb});
    end
    en <= 4'hF;
    wt(5);
    $display("test levels done");
  endtask
  task automatic t_detect();
    wr(`EQC_REG_INT_MASK, 32'h101);
    amp0 <= 8'h46;
    wt(3);
    chk("detect", 32'h1, {28'h0, sd});
    chk("irq", 32'h1, {31'h0, irq});
    amp0 <= 8'h29;
    wt(3);
    chk("detect", 32'h1, {28'h0, sd});
    amp0 <= 8'h28;
    amp1 <= 8'h5A;
    amp2 <= 8'h45;
    wt(3);
    chk("detect", 32'h2, {28'h0, sd});
    rd("int_stat", `EQC_REG_INT_STAT, 32'h13, 1'b0);
    wr(`EQC_REG_INT_STAT, 32'h1FF);
    wt(2);
    chk("irq", 32'h0, {31'h0, irq});
    en <= 4'hD;
    wt(5);
    chk("detect", 32'h0, {28'h0, sd});
    en <= 4'hF;
    amp1 <= 8'h0;
    amp2 <= 8'h0;
    wt(5);
    // programmed levels tried on channel 3 only; the levels are shared, so every channel uses them until the defaults are rewritten
    wr(`EQC_REG_THRESH, 32'h3050);
    rd("thresh", `EQC_REG_THRESH, 32'h3050, 1'b0);
    amp3 <= 8'h4F;
    wt(3);
    chk("detect", 32'h0, {28'h0, sd});
    amp3 <= 8'h50;
    wt(3);
    chk("detect", 32'h8, {28'h0, sd});
    amp3 <= 8'h31;
    wt(3);
    chk("detect", 32'h8, {28'h0, sd});
    amp3 <= 8'h30;
    wt(3);
    chk("detect", 32'h0, {28'h0, sd});
    rd("int_stat", `EQC_REG_INT_STAT, 32'hA8, 1'b0);
    wr(`EQC_REG_THRESH, 32'h2846);
    wr(`EQC_REG_INT_STAT, 32'h1FF);
    $display("test detect done");
  endtask
  task automatic t_serial();
    acc <= 1'b1;
    wt(5);
    eqc_smb_host_inst.start_frame();
    smb({`EQC_SMB_ADDR, 1'b0}, 1'b1);
    smb(8'h02, 1'b1);
    smb(8'h06, 1'b1);
    smb(8'h02, 1'b1);
    eqc_smb_host_inst.stop_frame();
    rd("boost", `EQC_REG_BOOST, 32'h2631, 1'b0);
    src <= 1'b0;
    wt(5);
    chk("eq", 32'h599, {20'h0, eqv});
    acc <= 1'b0;
    wt(5);
    eqc_smb_host_inst.start_frame();
    smb({`EQC_SMB_ADDR, 1'b0}, 1'b0);
    eqc_smb_host_inst.stop_frame();
    acc <= 1'b1;
    wt(5);
    // a read request is refused, and the bytes after it must not reach the register
    eqc_smb_host_inst.start_frame();
    smb({`EQC_SMB_ADDR, 1'b1}, 1'b0);
    smb(8'h00, 1'b0);
    eqc_smb_host_inst.stop_frame();
    rd("boost", `EQC_REG_BOOST, 32'h2631, 1'b0);
    eqc_smb_host_inst.start_frame();
    eqc_smb_host_inst.wt(250);
    eqc_smb_host_inst.stop_frame();
    rd("int_stat", `EQC_REG_INT_STAT, 32'h100, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`EQC_REG_INT_STAT, 32'h100);
    wt(2);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test serial done");
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    wt(20000);
    bad_count++;
    results();
  end
  initial begin
    wt(16);
    presetn <= 1'b1;
    wt(6);
    t_reset();
    t_levels();
    t_detect();
    t_serial();
    results();
  end
endmodule
